// File: pkg/rir_pkg.sv
package rir_pkg;
    // Stage numbering used for start/trip inputs.
    localparam int STAGE_COUNT = 6;
    localparam int STG_OC_LOW = 0;
    localparam int STG_OC_HIGH = 1;
    localparam int STG_OC_INST = 2;
    localparam int STG_EF_LOW = 3;
    localparam int STG_EF_HIGH = 4;
    localparam int STG_PHASE_DISC = 5;
    // Event code numbers, as on the display and the read parameter.
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_OC_LOW_START = 4'h1;
    localparam logic [3:0] CODE_OC_LOW_TRIP = 4'h2;
    localparam logic [3:0] CODE_OC_HIGH_START = 4'h3;
    localparam logic [3:0] CODE_OC_HIGH_TRIP = 4'h4;
    localparam logic [3:0] CODE_OC_INST_START = 4'h5;
    localparam logic [3:0] CODE_OC_INST_TRIP = 4'h6;
    localparam logic [3:0] CODE_EF_LOW_START = 4'h7;
    localparam logic [3:0] CODE_EF_LOW_TRIP = 4'h8;
    localparam logic [3:0] CODE_EF_HIGH_START = 4'h9;
    localparam logic [3:0] CODE_EF_HIGH_TRIP = 4'h0;
    localparam logic [3:0] CODE_PHASE_DISC_TRIP = 4'hb;
    localparam logic [3:0] CODE_BREAKER_FAIL = 4'hc;
    // Positions of the reset-action bits in each external input switch group.
    localparam int EXT_CLEAR_IND_BIT = 6;
    localparam int EXT_UNLATCH_BIT = 7;
    localparam int EXT_ERASE_BIT = 8;
    localparam int SW_GROUP_W = 8;
    localparam int EXT_INPUTS = 3;
    localparam int TRIP_OUTS = 4;
    localparam int FAULT_CODE_W = 10;
    // Trip-indicator modes selected by trip_led_mode_switches bits.
    localparam int LED_ON_TRIP_BIT = 0;
endpackage : rir_pkg

// File: logic/rir_indication.sv
module rir_indication
    import rir_pkg::*;
#(
    parameter int N_STG = STAGE_COUNT,
    parameter int N_TRIP = TRIP_OUTS
) (
    input wire logic core_clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic reset_button, // Front-panel reset button.
    input wire logic program_button, // Front-panel program button.
    input wire logic display_dark, // Display is dark.
    input wire logic ext_ctrl_in_a, // External control input a.
    input wire logic ext_ctrl_in_b, // External control input b.
    input wire logic ext_ctrl_in_c, // External control input c.
    input wire logic [3*SW_GROUP_W-1:0] ext_input_switch_groups, // Three groups, bit 1 at lsb.
    input wire logic unlatch_command, // Bus unlatch command pulse.
    input wire logic full_clear_command, // Bus full-clear command pulse.
    input wire logic [N_STG-1:0] stage_start, // Stage start levels.
    input wire logic [N_STG-1:0] stage_trip, // Stage trip levels.
    input wire logic breaker_fail_trip, // Breaker failure unit operation.
    input wire logic [2:0] phase_over_start, // Phase currents above start threshold.
    input wire logic [4:0] start_latch_switches, // Start code latching per stage.
    input wire logic [SW_GROUP_W-1:0] trip_led_mode_switches, // Trip indicator mode.
    input wire logic [N_TRIP-1:0] trip_drive, // Trip output causing signals.
    input wire logic [N_TRIP-1:0] self_hold_switches, // Self-holding per trip output.
    input wire logic internal_fault, // Permanent internal fault detected.
    input wire logic [FAULT_CODE_W-1:0] fault_code_in, // Internal fault code number.
    output logic [3:0] event_code_read_param, // Displayed and readable code.
    output logic event_code_valid, // A code is being shown.
    output logic trip_led, // Shared trip indicator.
    output logic [2:0] phase_fault_led, // Phase fault indicators.
    output logic [N_TRIP-1:0] trip_outputs, // Trip output relays.
    output logic self_supervision_alarm, // Alarm indicator.
    output logic supervision_relay, // Self-supervision output relay drive.
    output logic fault_code_shown, // Fault code with leading one shown.
    output logic [FAULT_CODE_W-1:0] fault_code, // Held internal fault code.
    output logic clear_ind_pulse, // Indicators cleared this cycle.
    output logic unlatch_pulse, // Outputs unlatched this cycle.
    output logic erase_pulse // Recorded registers erased this cycle.
);

    // Edge detection registers for buttons and external inputs.
    logic [1:0] btn_q;
    logic [EXT_INPUTS-1:0] ext_q;
    logic [1:0] next_btn_q;
    logic [EXT_INPUTS-1:0] next_ext_q;
    logic [EXT_INPUTS-1:0] ext_rise;
    logic [EXT_INPUTS-1:0] ext_now;
    logic do_clear;
    logic do_unlatch;
    logic do_erase;

    assign ext_now = {ext_ctrl_in_c, ext_ctrl_in_b, ext_ctrl_in_a};

    always_comb begin
        next_btn_q = {program_button, reset_button};
        next_ext_q = ext_now;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            btn_q <= 2'b00;
            ext_q <= '0;
        end else begin
            btn_q <= next_btn_q;
            ext_q <= next_ext_q;
        end
    end

    assign ext_rise = ext_now & ~ext_q;

    // Both buttons count as one combined press on the edge that completes the pair.
    logic both_now;
    logic both_q;
    logic rst_rise;
    logic prog_rise;
    logic both_rise;
    assign both_now = reset_button & program_button;
    assign both_q = btn_q[0] & btn_q[1];
    assign both_rise = both_now & ~both_q;
    assign rst_rise = reset_button & ~btn_q[0];
    assign prog_rise = program_button & ~btn_q[1] & display_dark;

    logic ext_clear;
    logic ext_unlatch;
    logic ext_erase;
    logic [EXT_INPUTS-1:0] ext_clear_req;
    logic [EXT_INPUTS-1:0] ext_unlatch_req;
    logic [EXT_INPUTS-1:0] ext_erase_req;

    // Each input has its own switch group; bit n of a group sits at index n-1.
    for (genvar i = 0; i < EXT_INPUTS; i++) begin : g_ext_input
        logic sw_clear;
        logic sw_unlatch;
        logic sw_erase;

        assign sw_clear = ext_input_switch_groups[i*SW_GROUP_W + EXT_CLEAR_IND_BIT - 1];
        assign sw_unlatch = ext_input_switch_groups[i*SW_GROUP_W + EXT_UNLATCH_BIT - 1];
        assign sw_erase = ext_input_switch_groups[i*SW_GROUP_W + EXT_ERASE_BIT - 1];
        // A stronger action always includes the weaker ones.
        assign ext_erase_req[i] = ext_rise[i] & sw_erase;
        assign ext_unlatch_req[i] = ext_rise[i] & (sw_unlatch | sw_erase);
        assign ext_clear_req[i] = ext_rise[i] & (sw_clear | sw_unlatch | sw_erase);
    end

    assign ext_erase = |ext_erase_req;
    assign ext_unlatch = |ext_unlatch_req;
    assign ext_clear = |ext_clear_req;

    // All sources OR together so no request is lost when they coincide.
    assign do_erase = both_rise | full_clear_command | ext_erase;
    assign do_unlatch = do_erase | prog_rise | unlatch_command | ext_unlatch;
    assign do_clear = do_unlatch | rst_rise | ext_clear;

    // Indication state.
    logic [N_STG-1:0] start_mem;
    logic [N_STG-1:0] trip_mem;
    logic [N_STG-1:0] next_start_mem;
    logic [N_STG-1:0] next_trip_mem;
    logic [N_STG-1:0] start_latch_en;
    logic bf_mem;
    logic next_bf_mem;
    logic next_trip_led;
    logic [2:0] next_phase_led;
    logic [3:0] next_code;
    logic next_code_valid;
    logic any_trip;

    assign any_trip = (|stage_trip) | breaker_fail_trip;

    // Phase discontinuity has no start code, so stages past the switch field never latch.
    for (genvar s = 0; s < N_STG; s++) begin : g_latch_en
        if (s < $bits(start_latch_switches)) begin : g_switch
            assign start_latch_en[s] = start_latch_switches[s];
        end else begin : g_none
            assign start_latch_en[s] = 1'b0;
        end
    end

    // Code table per stage.
    function automatic logic [3:0] start_code(input int s);
        unique case (s)
            STG_OC_LOW: start_code = CODE_OC_LOW_START;
            STG_OC_HIGH: start_code = CODE_OC_HIGH_START;
            STG_OC_INST: start_code = CODE_OC_INST_START;
            STG_EF_LOW: start_code = CODE_EF_LOW_START;
            STG_EF_HIGH: start_code = CODE_EF_HIGH_START;
            default: start_code = CODE_NONE;
        endcase
    endfunction : start_code

    function automatic logic [3:0] trip_code(input int s);
        unique case (s)
            STG_OC_LOW: trip_code = CODE_OC_LOW_TRIP;
            STG_OC_HIGH: trip_code = CODE_OC_HIGH_TRIP;
            STG_OC_INST: trip_code = CODE_OC_INST_TRIP;
            STG_EF_LOW: trip_code = CODE_EF_LOW_TRIP;
            STG_EF_HIGH: trip_code = CODE_EF_HIGH_TRIP;
            default: trip_code = CODE_PHASE_DISC_TRIP;
        endcase
    endfunction : trip_code

    // One start memory and one trip memory per protection stage.
    for (genvar s = 0; s < N_STG; s++) begin : g_stage_mem
        // New events set over a clear in the same cycle.
        always_comb begin
            next_trip_mem[s] = stage_trip[s] | (trip_mem[s] & ~do_clear);
            if (start_latch_en[s]) begin
                next_start_mem[s] = stage_start[s] | (start_mem[s] & ~do_clear);
            end else begin
                next_start_mem[s] = stage_start[s];
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                start_mem[s] <= 1'b0;
                trip_mem[s] <= 1'b0;
            end else begin
                start_mem[s] <= next_start_mem[s];
                trip_mem[s] <= next_trip_mem[s];
            end
        end
    end

    // Breaker failure memory.
    always_comb begin
        next_bf_mem = breaker_fail_trip | (bf_mem & ~do_clear);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bf_mem <= 1'b0;
        end else begin
            bf_mem <= next_bf_mem;
        end
    end

    // Shared trip indicator and phase fault indicators.
    always_comb begin
        if (trip_led_mode_switches[LED_ON_TRIP_BIT]) begin
            next_trip_led = any_trip | (trip_led & ~do_clear);
        end else begin
            next_trip_led = any_trip;
        end
        // Only the reset button clears the phase indicators; bus commands leave them lit.
        next_phase_led = (any_trip ? phase_over_start : 3'b000)
            | (phase_fault_led & ~{3{rst_rise}});
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            trip_led <= 1'b0;
            phase_fault_led <= 3'b000;
        end else begin
            trip_led <= next_trip_led;
            phase_fault_led <= next_phase_led;
        end
    end

    // Display code, shared with the read parameter so both always agree.
    always_comb begin
        next_code = CODE_NONE;
        next_code_valid = 1'b0;
        // Lowest stage number wins; a trip hides the same stage's start.
        for (int s = N_STG - 1; s >= 0; s--) begin
            if (next_trip_mem[s]) begin
                next_code = trip_code(s);
                next_code_valid = 1'b1;
            end else if (next_start_mem[s] && s != STG_PHASE_DISC) begin
                next_code = start_code(s);
                next_code_valid = 1'b1;
            end
        end
        if (next_bf_mem) begin
            next_code = CODE_BREAKER_FAIL;
            next_code_valid = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            event_code_read_param <= CODE_NONE;
            event_code_valid <= 1'b0;
        end else begin
            event_code_read_param <= next_code;
            event_code_valid <= next_code_valid;
        end
    end

    // Action pulses tell the rest of the design, outside this module, what was cleared this cycle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clear_ind_pulse <= 1'b0;
            unlatch_pulse <= 1'b0;
            erase_pulse <= 1'b0;
        end else begin
            clear_ind_pulse <= do_clear;
            unlatch_pulse <= do_unlatch;
            erase_pulse <= do_erase;
        end
    end

    // One self-holding stage per trip relay.
    for (genvar t = 0; t < N_TRIP; t++) begin : g_trip_out
        logic next_out;

        // The hold path reads only its own relay, so latched indicators cannot steer an output.
        always_comb begin
            next_out = trip_drive[t] | (self_hold_switches[t] & trip_outputs[t] & ~do_unlatch);
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                trip_outputs[t] <= 1'b0;
            end else begin
                trip_outputs[t] <= next_out;
            end
        end
    end

    // Self-supervision: sticky until power-on reset only; no reset source touches it.
    logic next_alarm;
    logic [FAULT_CODE_W-1:0] next_fault_code;

    always_comb begin
        next_alarm = self_supervision_alarm | internal_fault;
    end

    // Lamp and relay share one next value so they can never disagree.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            self_supervision_alarm <= 1'b0;
            supervision_relay <= 1'b0;
            fault_code_shown <= 1'b0;
        end else begin
            self_supervision_alarm <= next_alarm;
            supervision_relay <= next_alarm;
            fault_code_shown <= next_alarm;
        end
    end

    // The first code is kept, so a later fault cannot overwrite what service needs to see.
    always_comb begin
        next_fault_code = fault_code;
        if (internal_fault && !self_supervision_alarm) begin
            next_fault_code = fault_code_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fault_code <= '0;
        end else begin
            fault_code <= next_fault_code;
        end
    end

endmodule : rir_indication

// File: verification/rir_monitor.sv
module rir_monitor
    import rir_pkg::*;
#(
    parameter int N_STG = STAGE_COUNT,
    parameter int N_TRIP = TRIP_OUTS
) (
    input wire logic core_clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic reset_button, // Button.
    input wire logic program_button, // Button.
    input wire logic ext_ctrl_in_a, // Input a.
    input wire logic [3*SW_GROUP_W-1:0] ext_input_switch_groups, // Switches.
    input wire logic unlatch_command, // Command.
    input wire logic full_clear_command, // Command.
    input wire logic [N_STG-1:0] stage_trip, // Trips.
    input wire logic breaker_fail_trip, // Breaker failure.
    input wire logic [SW_GROUP_W-1:0] trip_led_mode_switches, // Mode.
    input wire logic [N_TRIP-1:0] self_hold_switches, // Self hold.
    input wire logic internal_fault, // Fault.
    input wire logic [3:0] event_code_read_param, // Code.
    input wire logic event_code_valid, // Code shown.
    input wire logic trip_led, // Trip indicator.
    input wire logic [N_TRIP-1:0] trip_outputs, // Trip relays.
    input wire logic self_supervision_alarm, // Alarm.
    input wire logic supervision_relay, // Relay.
    input wire logic [FAULT_CODE_W-1:0] fault_code, // Held code.
    input wire logic clear_ind_pulse, // Clear.
    input wire logic unlatch_pulse, // Unlatch.
    input wire logic erase_pulse // Erase.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_both;
        reset_button && program_button && ($rose(reset_button) || $rose(program_button));
    endsequence
    sequence s_led_held;
        trip_led && trip_led_mode_switches[0] ##1 !clear_ind_pulse && trip_led_mode_switches[0];
    endsequence
    sequence s_out_held;
        trip_outputs[0] && self_hold_switches[0] ##1 !unlatch_pulse && self_hold_switches[0];
    endsequence
    AST_CLR_BTN: assert property ($rose(reset_button) |=> clear_ind_pulse)
        else $error("clear missing");
    AST_BOTH: assert property (s_both |=> erase_pulse && unlatch_pulse && clear_ind_pulse)
        else $error("erase missing");
    AST_CMD: assert property (unlatch_command || full_clear_command |=> unlatch_pulse && clear_ind_pulse)
        else $error("command ignored");
    AST_EXT: assert property ($rose(ext_ctrl_in_a) && ext_input_switch_groups[EXT_ERASE_BIT-1] |=> erase_pulse)
        else $error("external erase missing");
    AST_TRIP: assert property (stage_trip[0] && !breaker_fail_trip |=> event_code_valid && trip_led &&
        event_code_read_param == CODE_OC_LOW_TRIP) else $error("trip code wrong");
    AST_LED_HOLD: assert property (s_led_held |-> trip_led)
        else $error("trip indicator lost");
    AST_HOLD_OUT: assert property (s_out_held |-> trip_outputs[0])
        else $error("held output lost");
    AST_ALARM: assert property (internal_fault |=> self_supervision_alarm && supervision_relay)
        else $error("alarm missing");
    AST_ALARM_KEEP: assert property (self_supervision_alarm |=> self_supervision_alarm && $stable(fault_code))
        else $error("fault code changed");
endmodule : rir_monitor

bind rir_indication rir_monitor #(.N_STG(N_STG), .N_TRIP(N_TRIP)) u_mon (.*);

// File: verification/rir_far_side.sv
module rir_far_side (
    input wire logic core_clk, // Clock.
    input wire logic [6:0] req, // Sources to apply.
    output logic reset_button, // Button.
    output logic program_button, // Button.
    output logic ext_ctrl_in_a, // Input a.
    output logic ext_ctrl_in_b, // Input b.
    output logic ext_ctrl_in_c, // Input c.
    output logic unlatch_command, // Command.
    output logic full_clear_command // Command.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] held = 5'h00;
    logic [1:0] cmd = 2'h0;
    logic [1:0] cnt = 2'h0;
    // Presses last three cycles, so a design acting on the level would act more than once.
    assign {ext_ctrl_in_c, ext_ctrl_in_b, ext_ctrl_in_a, program_button, reset_button} = held;
    assign {full_clear_command, unlatch_command} = cmd;
    always @(posedge core_clk) begin
        cmd <= req[6:5];
        if (req != 7'h00) begin
            held <= req[4:0];
            cnt <= 2'h3;
        end else if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
            held <= (cnt == 2'h1) ? 5'h00 : held;
        end
    end
endmodule : rir_far_side

// File: verification/rir_indication_tb.sv
module rir_indication_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rst = 1'b1, display_dark = 1'b0, breaker_fail_trip = 1'b0, internal_fault = 1'b0;
    logic [23:0] ext_input_switch_groups = 24'h00_0000, sw;
    logic [5:0] stage_start = 6'h00, stage_trip = 6'h00;
    logic [2:0] phase_over_start = 3'h0, phase_fault_led, e;
    logic [4:0] start_latch_switches = 5'h00;
    logic [7:0] trip_led_mode_switches = 8'h01;
    logic [3:0] trip_drive = 4'h0, self_hold_switches = 4'h0, trip_outputs, event_code_read_param, pc, pu, pe;
    logic [9:0] fault_code_in = 10'h000, fault_code;
    logic [6:0] req = 7'h00, m;
    logic reset_button, program_button, ext_ctrl_in_a, ext_ctrl_in_b, ext_ctrl_in_c, unlatch_command, d;
    logic full_clear_command, event_code_valid, trip_led, self_supervision_alarm, supervision_relay;
    logic fault_code_shown, clear_ind_pulse, unlatch_pulse, erase_pulse;
    logic [3:0] nc = 4'h0, nu = 4'h0, ne = 4'h0;
    int error_cnt = 0, n_compared = 0;
    logic [3:0] tcode [6] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'h0, 4'hb};
    logic [3:0] scode [5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h9};
    logic [34:0] tbl [12] = '{{7'h01, 1'h0, 24'h00_0000, 3'h4}, {7'h02, 1'h1, 24'h00_0000, 3'h6},
        {7'h02, 1'h0, 24'h00_0000, 3'h0}, {7'h03, 1'h0, 24'h00_0000, 3'h7}, {7'h04, 1'h0, 24'h00_0020, 3'h4},
        {7'h08, 1'h0, 24'h00_4000, 3'h6}, {7'h10, 1'h0, 24'h80_0000, 3'h7}, {7'h1c, 1'h0, 24'h00_0000, 3'h0},
        {7'h04, 1'h0, 24'h00_0080, 3'h7}, {7'h20, 1'h0, 24'h00_0000, 3'h6}, {7'h40, 1'h0, 24'h00_0000, 3'h7},
        {7'h21, 1'h0, 24'h00_0000, 3'h6}};
    rir_indication u_dut (.*);
    rir_far_side u_far (.*);
    initial forever #20 core_clk = ~core_clk;
    // Counting every pulse cycle shows both a missed action and a repeated one.
    always @(posedge core_clk) begin
        nc <= nc + 4'(clear_ind_pulse === 1'b1);
        nu <= nu + 4'(unlatch_pulse === 1'b1);
        ne <= ne + 4'(erase_pulse === 1'b1);
    end
    task summarize;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task see(input logic v, input logic [3:0] c, input logic l, input logic [2:0] p);
        @(posedge core_clk);
        #1 chk(16'({event_code_valid, event_code_read_param, trip_led, phase_fault_led}), 16'({v, c, l, p}));
    endtask : see
    task press(input logic [6:0] mask);
        @(posedge core_clk) req <= mask;
        @(posedge core_clk) req <= 7'h00;
        repeat (8) @(posedge core_clk);
        #1;
    endtask : press
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        foreach (tbl[i]) begin
            {m, d, sw, e} = tbl[i];
            @(posedge core_clk) display_dark <= d;
            ext_input_switch_groups <= sw;
            {pc, pu, pe} = {nc, nu, ne};
            press(m);
            chk(16'({nc - pc, nu - pu, ne - pe}), 16'({3'h0, e[2], 3'h0, e[1], 3'h0, e[0]}));
        end
        foreach (tcode[s]) begin
            @(posedge core_clk) stage_trip <= 6'h01 << s;
            phase_over_start <= 3'h5;
            @(posedge core_clk) stage_trip <= 6'h00;
            see(1'b1, tcode[s], 1'b1, 3'h5);
            press(7'h01);
            see(1'b0, 4'h0, 1'b0, 3'h0);
        end
        foreach (scode[s]) begin
            @(posedge core_clk) stage_start <= 6'h01 << s;
            see(1'b1, scode[s], 1'b0, 3'h0);
            @(posedge core_clk) stage_start <= 6'h00;
            see(1'b0, 4'h0, 1'b0, 3'h0);
            @(posedge core_clk) stage_start <= 6'h01 << s;
            start_latch_switches <= 5'h01 << s;
            @(posedge core_clk) stage_start <= 6'h00;
            see(1'b1, scode[s], 1'b0, 3'h0);
            @(posedge core_clk) stage_trip <= 6'h01 << s;
            see(1'b1, tcode[s], 1'b1, 3'h5);
            @(posedge core_clk) stage_trip <= 6'h00;
            start_latch_switches <= 5'h00;
            press(7'h01);
        end
        @(posedge core_clk) trip_led_mode_switches <= 8'h00;
        stage_trip <= 6'h01;
        @(posedge core_clk) stage_trip <= 6'h00;
        see(1'b1, 4'h2, 1'b0, 3'h5);
        press(7'h01);
        @(posedge core_clk) breaker_fail_trip <= 1'b1;
        @(posedge core_clk) breaker_fail_trip <= 1'b0;
        #1 chk(16'({event_code_valid, event_code_read_param}), 16'h001c);
        @(posedge core_clk) self_hold_switches <= 4'h1;
        trip_drive <= 4'h3;
        @(posedge core_clk) trip_drive <= 4'h0;
        #1 chk(16'(trip_outputs), 16'h0003);
        press(7'h01);
        chk(16'(trip_outputs), 16'h0001);
        press(7'h20);
        chk(16'(trip_outputs), 16'h0000);
        @(posedge core_clk) internal_fault <= 1'b1;
        fault_code_in <= 10'h2a5;
        @(posedge core_clk) internal_fault <= 1'b0;
        fault_code_in <= 10'h011;
        press(7'h43);
        chk(16'({self_supervision_alarm, supervision_relay, fault_code_shown, fault_code}), 16'h1ea5);
        summarize();
    end
endmodule : rir_indication_tb
